// ### design/byte_serial_crc16.sv
// byte serial crc16 generator with avalon-mm register slave
// Operation
// - byte write folds into running 16-bit checksum
// - update finishes within one clock cycle
// - control bit 0 selects polynomial, resets 0
// - only CCITT and CRC-16 polynomials exist
// - input byte xors into checksum high byte
// - shift left, xor polynomial when msb set
// - constants 8005H for CRC-16, 1021H CCITT
// - eight steps; result becomes new checksum
// - high/low checksum bytes read/write, reset zero
// - input byte register read/write, resets zero
// - control bits 7 to 1 read zero
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`include "crc16_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module byte_serial_crc16 #(
  // documented sizes; other values are refused below
  parameter int unsigned BYTE_W = 8,   // input byte width
  parameter int unsigned SUM_W  = 16,  // checksum width
  parameter int unsigned STEPS  = 8    // shift steps per byte
) (
  // clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        clk_en_i,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // checksum view
  output logic      [15:0] running_checksum_o
);
  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [7:0]             crc_byte_in_reg;    // last byte fed
  logic [7:0]             crc_byte_in_next;
  logic [15:0]            sum_reg;            // running checksum
  logic [15:0]            sum_next;
  crc16_pkg::polynomial_select_sel_e   polynomial_select_reg;           // polynomial_select
  crc16_pkg::polynomial_select_sel_e   polynomial_select_next;
  crc16_pkg::bus_state_e  bus_reg;            // answer phase
  crc16_pkg::bus_state_e  bus_next;
  logic [31:0]            rdata_reg;          // read data
  logic [31:0]            rdata_next;
  crc16_pkg::bus_req_s    req;                // decoded request
  logic [15:0]            folded;             // checksum after one byte
  logic                   take;               // request accepted this cycle
  logic                   wait_reg;           // registered waitrequest
  logic                   wait_next;
  logic [15:0]            polynomial_select_word;          // constant for the bit steps
  logic [15:0]            stage [0:STEPS];    // partial sums, one per bit step

  // --------------------------------------------------------------------------
  // parameter check
  // --------------------------------------------------------------------------
  // the datapath is wired for byte input and a 16-bit sum only
  if (BYTE_W != 8 || SUM_W != 16 || STEPS != BYTE_W) begin : g_bad_size
    $error("byte_serial_crc16: only 8-bit bytes, 16-bit sum and 8 steps are served");
  end

  // --------------------------------------------------------------------------
  // crc datapath
  // --------------------------------------------------------------------------
  // polynomial constant for the bit steps; only two exist, nothing programmable
  assign polynomial_select_word = (polynomial_select_reg == crc16_pkg::POLYNOMIAL_SELECT_CRC16) ? `CRC_POLYNOMIAL_SELECT_16 : `CRC_POLYNOMIAL_SELECT_CCITT;
  // the byte goes into the high half before any shifting
  assign stage[0] = {sum_reg[15:8] ^ avs_writedata_i[7:0], sum_reg[7:0]};
  // eight unrolled steps in one cycle, so the new sum is ready next cycle
  // trade-off: a long xor chain instead of a multi-cycle shifter
  for (genvar g = 0; g < STEPS; g++) begin : g_step
    // shift in a zero; fold in the polynomial when the msb leaves as one
    assign stage[g+1] = stage[g][15] ? ({stage[g][14:0], 1'b0} ^ polynomial_select_word)
                                     : {stage[g][14:0], 1'b0};
  end
  // last stage is the new checksum
  assign folded = stage[STEPS];

  // request bundle decoded from the bus; a write wins over a simultaneous read
  always_comb begin
    req.wr    = avs_write_i;
    req.rd    = avs_read_i & ~avs_write_i;
    req.addr  = avs_address_i;
    req.wdata = avs_writedata_i[7:0];
  end

  // --------------------------------------------------------------------------
  // bus handshake: one wait cycle, answer on the second edge
  // --------------------------------------------------------------------------
  // a fixed one-cycle wait keeps read data registered and writes single-shot
  always_comb begin
    take      = 1'b0;
    bus_next  = bus_reg;
    wait_next = 1'b1;                    // idle or answered: keep the master waiting
    case (bus_reg)
      crc16_pkg::BUS_IDLE: begin
        if (req.wr | req.rd) begin
          bus_next  = crc16_pkg::BUS_DONE;
          wait_next = 1'b0;              // answer stands in the next cycle
        end
      end
      crc16_pkg::BUS_DONE: begin
        take     = 1'b1;                 // waitrequest low now
        bus_next = crc16_pkg::BUS_IDLE;
      end
      default: begin
        bus_next = crc16_pkg::BUS_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // register file next state
  // --------------------------------------------------------------------------
  always_comb begin
    crc_byte_in_next = crc_byte_in_reg;
    sum_next         = sum_reg;
    polynomial_select_next        = polynomial_select_reg;
    rdata_next       = rdata_reg;
    // read data is prepared during the wait cycle
    if (bus_reg == crc16_pkg::BUS_IDLE && req.rd) begin
      case (req.addr)
        `CRC_BYTE_IN_OFS:      rdata_next = {24'h000000, crc_byte_in_reg};
        `CRC_SUM_LOW_OFS:      rdata_next = {24'h000000, sum_reg[7:0]};
        `CRC_SUM_HIGH_OFS:     rdata_next = {24'h000000, sum_reg[15:8]};
        `CRC_POLYNOMIAL_SELECT_CONTROL_OFS: rdata_next = {31'h00000000, polynomial_select_reg};
        default:               rdata_next = `CRC_UNMAPPED_DATA;
      endcase
    end
    // writes commit on the edge where waitrequest is low
    if (take && req.wr && avs_byteenable_i[0]) begin
      case (req.addr)
        `CRC_BYTE_IN_OFS: begin
          crc_byte_in_next = req.wdata;
          sum_next         = folded;
        end
        `CRC_SUM_LOW_OFS: begin
          sum_next[7:0] = req.wdata;
        end
        `CRC_SUM_HIGH_OFS: begin
          sum_next[15:8] = req.wdata;
        end
        `CRC_POLYNOMIAL_SELECT_CONTROL_OFS: begin
          polynomial_select_next = crc16_pkg::polynomial_select_sel_e'(req.wdata[`CRC_POLYNOMIAL_SELECT_SEL_BIT]);
        end
        default: begin
          sum_next = sum_reg;            // unmapped write ignored
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      crc_byte_in_reg <= `CRC_BYTE_RST;
      sum_reg         <= `CRC_SUM_RST;
      polynomial_select_reg        <= crc16_pkg::POLYNOMIAL_SELECT_CCITT;
      bus_reg         <= crc16_pkg::BUS_IDLE;
      rdata_reg       <= 32'h00000000;
      wait_reg        <= 1'b1;
    end else if (clk_en_i) begin
      crc_byte_in_reg <= crc_byte_in_next;
      sum_reg         <= sum_next;
      polynomial_select_reg        <= polynomial_select_next;
      bus_reg         <= bus_next;
      rdata_reg       <= rdata_next;
      wait_reg        <= wait_next;
    end
  end

  // outputs straight from flip-flops
  assign avs_readdata_o     = rdata_reg;
  assign avs_waitrequest_o  = wait_reg;
  assign running_checksum_o = sum_reg;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  logic wr_in_done;
  assign wr_in_done = take && clk_en_i && req.wr && avs_byteenable_i[0];

  a_byte_fold_update: assert property (
    wr_in_done && req.addr == `CRC_BYTE_IN_OFS |=> sum_reg == $past(folded))
    else $error("checksum not folded after byte write");
  a_fold_one_cycle: assert property (
    wr_in_done && req.addr == `CRC_BYTE_IN_OFS && req.wdata == 8'h01 &&
    sum_reg == 16'h0000 && polynomial_select_reg == crc16_pkg::POLYNOMIAL_SELECT_CCITT |=> sum_reg == 16'h1021)
    else $error("ccitt single byte result wrong");
  a_crc16_constant: assert property (
    wr_in_done && req.addr == `CRC_BYTE_IN_OFS && req.wdata == 8'h01 &&
    sum_reg == 16'h0000 && polynomial_select_reg == crc16_pkg::POLYNOMIAL_SELECT_CRC16 |=> sum_reg == 16'h8005)
    else $error("crc16 single byte result wrong");
  a_sum_stable: assert property (
    !wr_in_done |=> $stable(sum_reg))
    else $error("checksum moved without a write");
  a_low_write: assert property (
    wr_in_done && req.addr == `CRC_SUM_LOW_OFS |=>
    sum_reg[7:0] == $past(req.wdata) && sum_reg[15:8] == $past(sum_reg[15:8]))
    else $error("low checksum write wrong");
  a_high_write: assert property (
    wr_in_done && req.addr == `CRC_SUM_HIGH_OFS |=>
    sum_reg[15:8] == $past(req.wdata) && sum_reg[7:0] == $past(sum_reg[7:0]))
    else $error("high checksum write wrong");
  a_ctrl_read_zero: assert property (
    bus_reg == crc16_pkg::BUS_IDLE && req.rd && clk_en_i && req.addr == `CRC_POLYNOMIAL_SELECT_CONTROL_OFS
    |=> avs_readdata_o[31:1] == 31'h00000000 && !avs_waitrequest_o)
    else $error("control read upper bits not zero");
  a_polynomial_select_write: assert property (
    wr_in_done && req.addr == `CRC_POLYNOMIAL_SELECT_CONTROL_OFS |=> polynomial_select_reg == $past(req.wdata[0]))
    else $error("polynomial select not written");
  a_byte_reg: assert property (
    wr_in_done && req.addr == `CRC_BYTE_IN_OFS |=> crc_byte_in_reg == $past(req.wdata))
    else $error("input byte not stored");
  a_wait_bound: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o && clk_en_i |=> !avs_waitrequest_o)
    else $error("waitrequest held too long");
  // low never lasts two cycles, so each request lands once
  a_wait_single: assert property (
    !avs_waitrequest_o && clk_en_i |=> avs_waitrequest_o)
    else $error("waitrequest low for two cycles");
  // enable low holds checksum, control and handshake
  a_freeze_hold: assert property (
    !clk_en_i |=> $stable(sum_reg) && $stable(polynomial_select_reg) && $stable(avs_waitrequest_o))
    else $error("state moved while clock enable low");
  // a write with byte lane 0 off is answered but lands nowhere
  a_lane_off_ignored: assert property (
    take && clk_en_i && req.wr && !avs_byteenable_i[0] |=>
    $stable(sum_reg) && $stable(polynomial_select_reg) && $stable(crc_byte_in_reg))
    else $error("masked write changed a register");
  // low checksum byte read back as held at the request
  a_read_low: assert property (
    bus_reg == crc16_pkg::BUS_IDLE && req.rd && clk_en_i && req.addr == `CRC_SUM_LOW_OFS
    |=> avs_readdata_o == {24'h000000, $past(sum_reg[7:0])})
    else $error("low checksum read wrong");
  // high checksum byte read back as held at the request
  a_read_high: assert property (
    bus_reg == crc16_pkg::BUS_IDLE && req.rd && clk_en_i && req.addr == `CRC_SUM_HIGH_OFS
    |=> avs_readdata_o == {24'h000000, $past(sum_reg[15:8])})
    else $error("high checksum read wrong");
  // input byte register read back
  a_read_byte: assert property (
    bus_reg == crc16_pkg::BUS_IDLE && req.rd && clk_en_i && req.addr == `CRC_BYTE_IN_OFS
    |=> avs_readdata_o == {24'h000000, $past(crc_byte_in_reg)})
    else $error("input byte read wrong");
  // holes between the word-aligned registers read as zero
  a_unmapped_read: assert property (
    bus_reg == crc16_pkg::BUS_IDLE && req.rd && clk_en_i && req.addr[1:0] != 2'h0
    |=> avs_readdata_o == `CRC_UNMAPPED_DATA)
    else $error("unmapped read not zero");
  // every answer carries zero above the byte lane
  a_readdata_upper: assert property (
    !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  c_byte_write: cover property (wr_in_done && req.addr == `CRC_BYTE_IN_OFS);
  c_crc16_mode: cover property (wr_in_done && polynomial_select_reg == crc16_pkg::POLYNOMIAL_SELECT_CRC16);
  c_ctrl_read:  cover property (take && req.rd && req.addr == `CRC_POLYNOMIAL_SELECT_CONTROL_OFS);
  c_seed_write: cover property (wr_in_done && req.addr == `CRC_SUM_HIGH_OFS);
  c_freeze:     cover property (!clk_en_i && (avs_write_i || avs_read_i));
endmodule
`default_nettype wire

// ### design/crc16_defs.svh
// register offsets, field positions, reset values and constants of the byte crc unit
`ifndef CRC16_DEFS_SVH
`define CRC16_DEFS_SVH
// ----------------------------------------------------------------------------
// register byte addresses (word aligned)
// ----------------------------------------------------------------------------
`define CRC_BYTE_IN_OFS      4'h0
`define CRC_SUM_LOW_OFS      4'h4
`define CRC_SUM_HIGH_OFS     4'h8
`define CRC_POLYNOMIAL_SELECT_CONTROL_OFS 4'hC
// ----------------------------------------------------------------------------
// fields, reset values, polynomial constants
// ----------------------------------------------------------------------------
`define CRC_POLYNOMIAL_SELECT_SEL_BIT     0
`define CRC_BYTE_RST         8'h00
`define CRC_SUM_RST          16'h0000
`define CRC_POLYNOMIAL_SELECT_CCITT       16'h1021
`define CRC_POLYNOMIAL_SELECT_16          16'h8005
`define CRC_UNMAPPED_DATA    32'h00000000
`endif

// ### design/crc16_pkg.sv
// types shared by the byte crc unit
package crc16_pkg;
  // polynomial choice held in the control register
  typedef enum logic [0:0] {
    POLYNOMIAL_SELECT_CCITT = 1'b0,
    POLYNOMIAL_SELECT_CRC16 = 1'b1
  } polynomial_select_sel_e;
  // one decoded bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bus_req_s;
  // bus answer state
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_e;
endpackage

// ### verif/byte_serial_crc16_tb.sv
// self-checking testbench of the byte serial crc16 generator
`timescale 1ns/1ps
`default_nettype none
`include "crc16_defs.svh"
module byte_serial_crc16_tb;
  // ----------------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------------
  logic        core_clk_i       = 1'b0;    // 50 MHz system clock
  logic        srst_i           = 1'b1;    // held high for the first four edges
  logic        clk_en_i         = 1'b1;    // starts on; t_freeze drives it low to exercise freezing
  logic [3:0]  avs_address_i    = 4'h0;
  logic        avs_read_i       = 1'b0;
  logic        avs_write_i      = 1'b0;
  logic [31:0] avs_writedata_i  = 32'h00000000;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [15:0] running_checksum_o;
  int          err_total = 0;              // mismatches seen
  int          checks    = 0;              // comparisons made
  int          cycles    = 0;              // hang guard
  logic [31:0] q;                          // last read data
  always #10 core_clk_i = ~core_clk_i;
  byte_serial_crc16 dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .clk_en_i(clk_en_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .running_checksum_o(running_checksum_o));
  // ----------------------------------------------------------------------------
  // helpers: reference fold, bus cycle, compare, verdict
  // ----------------------------------------------------------------------------
  // bitwise reference, kept independent of the design's own code
  function automatic logic [15:0] fold(input logic [15:0] s, input logic [7:0] d, input logic p);
    logic [15:0] t;
    t = s ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      t = t[15] ? ((t << 1) ^ (p ? 16'h8005 : 16'h1021)) : (t << 1);
    end
    return t;
  endfunction
  // one request, held until waitrequest is sampled low; junk in upper data bits
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge core_clk_i);
    avs_write_i      <= w;
    avs_read_i       <= ~w;
    avs_address_i    <= a;
    avs_writedata_i  <= {24'hA5A5A5, d};
    avs_byteenable_i <= be;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 8'h00, 4'hF);
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  // reset values of all four registers plus four unmapped holes
  task automatic t_reset();
    for (int a = 0; a < 16; a += 2) begin
      rd(4'(a));
      chk("reset read", q, 32'h00000000);
    end
    chk("reset sum", {16'h0000, running_checksum_o}, 32'h00000000);
  endtask
  // only bit 0 of control survives; bit 1 set must not change polynomial
  task automatic t_control();
    wr(`CRC_POLYNOMIAL_SELECT_CONTROL_OFS, 8'hFF);
    rd(`CRC_POLYNOMIAL_SELECT_CONTROL_OFS);
    chk("ctrl ff", q, 32'h00000001);
    wr(`CRC_POLYNOMIAL_SELECT_CONTROL_OFS, 8'hFE);
    rd(`CRC_POLYNOMIAL_SELECT_CONTROL_OFS);
    chk("ctrl fe", q, 32'h00000000);
    wr(`CRC_BYTE_IN_OFS, 8'h5A);
    rd(`CRC_BYTE_IN_OFS);
    chk("byte in", q, 32'h0000005A);
    chk("ccitt fold", {16'h0000, running_checksum_o}, {16'h0000, fold(16'h0000, 8'h5A, 1'b0)});
  endtask
  // single bytes from a cleared sum, both polynomials, result readable next cycle
  task automatic t_single();
    logic [15:0] e;
    for (int p = 0; p < 2; p++) begin
      for (int d = 0; d < 8; d++) begin
        e = fold(16'h0000, 8'(d), 1'(p));
        wr(`CRC_POLYNOMIAL_SELECT_CONTROL_OFS, 8'(p));
        wr(`CRC_SUM_LOW_OFS, 8'h00);
        wr(`CRC_SUM_HIGH_OFS, 8'h00);
        wr(`CRC_BYTE_IN_OFS, 8'(d));
        @(negedge core_clk_i);
        chk("single sum", {16'h0000, running_checksum_o}, {16'h0000, e});
        rd(`CRC_SUM_HIGH_OFS);
        chk("sum high", q, {24'h000000, e[15:8]});
        rd(`CRC_SUM_LOW_OFS);
        chk("sum low", q, {24'h000000, e[7:0]});
      end
    end
  endtask
  // back-to-back byte stream against the published check vectors
  task automatic t_stream();
    logic [7:0]  b [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
    logic [15:0] v [8] = '{16'hFF9F, 16'hBBC3, 16'hA367, 16'hD0FA, 16'h0110, 16'h91F1, 16'hF2DE, 16'h5C43};
    for (int p = 0; p < 2; p++) begin
      wr(`CRC_SUM_LOW_OFS, 8'h00);
      wr(`CRC_SUM_HIGH_OFS, 8'h00);
      wr(`CRC_POLYNOMIAL_SELECT_CONTROL_OFS, 8'(p));
      for (int i = 0; i < 4; i++) begin
        wr(`CRC_BYTE_IN_OFS, b[i]);
        @(negedge core_clk_i);
        chk("stream sum", {16'h0000, running_checksum_o}, {16'h0000, v[p*4+i]});
      end
    end
  endtask
  // seeding by byte writes; masked and unmapped writes leave the sum alone
  task automatic t_seed();
    wr(`CRC_SUM_LOW_OFS, 8'h34);
    wr(`CRC_SUM_HIGH_OFS, 8'h12);
    bus(1'b1, `CRC_SUM_LOW_OFS, 8'hFF, 4'hE);
    wr(4'h1, 8'hFF);
    @(negedge core_clk_i);
    chk("seed sum", {16'h0000, running_checksum_o}, 32'h00001234);
    wr(`CRC_POLYNOMIAL_SELECT_CONTROL_OFS, 8'h01);
    wr(`CRC_BYTE_IN_OFS, 8'h56);
    @(negedge core_clk_i);
    chk("seeded fold", {16'h0000, running_checksum_o}, {16'h0000, fold(16'h1234, 8'h56, 1'b1)});
  endtask
  // enable low freezes handshake and sum; the held write lands once it returns
  task automatic t_freeze();
    logic [15:0] s;
    s = running_checksum_o;
    @(posedge core_clk_i);
    clk_en_i         <= 1'b0;
    avs_write_i      <= 1'b1;
    avs_address_i    <= `CRC_BYTE_IN_OFS;
    avs_writedata_i  <= 32'h00000077;
    avs_byteenable_i <= 4'hF;
    repeat (3) @(posedge core_clk_i);
    chk("frozen sum", {16'h0000, running_checksum_o}, {16'h0000, s});
    chk("frozen wait", {31'h00000000, avs_waitrequest_o}, 32'h00000001);
    clk_en_i <= 1'b1;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    @(negedge core_clk_i);
    chk("thawed fold", {16'h0000, running_checksum_o}, {16'h0000, fold(s, 8'h77, 1'b1)});
  endtask
  // ----------------------------------------------------------------------------
  // hang guard and main sequence
  // ----------------------------------------------------------------------------
  // the whole run needs well under two thousand cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_control();
    t_single();
    t_stream();
    t_seed();
    t_freeze();
    test_done();
  end
endmodule
`default_nettype wire
